// >>> core/fcmdsa_cfg.svh
`ifndef FCMDSA_CFG_SVH
`define FCMDSA_CFG_SVH
// multiply option codes
`define FCMDSA_MUL_NONE   2'h0
`define FCMDSA_MUL_LE     2'h1
`define FCMDSA_MUL_DSP    2'h2
`define FCMDSA_MUL_EMB    2'h3
// cycles per multiply instruction for each option
`define FCMDSA_CPI_LE     7'h0B
`define FCMDSA_CPI_DSP    7'h01
`define FCMDSA_CPI_EMB    7'h05
// extra result latency cycles
`define FCMDSA_LAT        7'h02
// partial product widths per option
`define FCMDSA_STEP_LE    6'h04
`define FCMDSA_STEP_EMB   6'h10
// divider bounds: quick-path count (min divide is this plus latency) and max cycles per divide
`define FCMDSA_DIV_MIN    7'h04
`define FCMDSA_DIV_MAX    7'h42
`define FCMDSA_DIV_STEPS  6'h20
// pipeline depth of the host core
`define FCMDSA_STAGES     3'h6
// shift amount field width
`define FCMDSA_SHW        5
`endif

// >>> core/fcmdsa_pkg.sv
`default_nettype none
package fcmdsa_pkg;
  typedef enum logic [3:0] {
    OP_ADD  = 4'h0, OP_ADDI = 4'h1, OP_MUL  = 4'h2, OP_MULI = 4'h3,
    OP_MULXSS = 4'h4, OP_MULXSU = 4'h5, OP_MULXUU = 4'h6,
    OP_DIV  = 4'h7, OP_DIVU = 4'h8, OP_SLL = 4'h9, OP_SRL = 4'hA,
    OP_SRA  = 4'hB, OP_ROL  = 4'hC, OP_ROR = 4'hD, OP_AND = 4'hE,
    OP_OR   = 4'hF
  } fcmdsa_op_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_MUL = 4'b0010, ST_DIV = 4'b0100,
    ST_SHF = 4'b1000
  } fcmdsa_st_e;
endpackage
`default_nettype wire

// >>> core/fcmdsa_res_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fcmdsa_res_if;
  logic        start;
  logic [31:0] value;
  logic [4:0]  dest;
  logic        valid;
  logic [31:0] data;
  logic [4:0]  wdest;
  modport src (output start, value, dest);
  modport dly (input start, value, dest, output valid, data, wdest);
endinterface
`default_nettype wire

// >>> core/fcmdsa_latency.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcmdsa_cfg.svh"
// delays a finished long result by the fixed latency before writeback
module fcmdsa_latency (
  input  wire logic   clk,
  input  wire logic   rst_n,
  fcmdsa_res_if.dly   res
);
  logic [1:0]  vld_ff;
  logic [31:0] d0_ff;
  logic [31:0] d1_ff;
  logic [4:0]  w0_ff;
  logic [4:0]  w1_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vld_ff <= 2'h0;
      d0_ff  <= 32'h0000_0000;
      d1_ff  <= 32'h0000_0000;
      w0_ff  <= 5'h00;
      w1_ff  <= 5'h00;
    end else begin
      vld_ff <= {vld_ff[0], res.start};
      d0_ff  <= res.value;
      d1_ff  <= d0_ff;
      w0_ff  <= res.dest;
      w1_ff  <= w0_ff;
    end
  end
  assign res.valid = vld_ff[1];
  assign res.data  = d1_ff;
  assign res.wdest = w1_ff;
endmodule
`default_nettype wire

// >>> core/fcmdsa_alu.sv
// How it works
// - no multiplier: mul raises unsupported exception; div traps only when DIV_EN is 0
// - logic option: 32x4, every 11 cycles
// - dsp option: 32x32, one per cycle, high words
// - embedded option: 32x16, every 5 cycles
// - divider takes 6 to 66 cycles, signed/unsigned
// - busy blocks issue faster than cycle count
// - simple ops finish in one cycle
// - with multiplier, shifts take one cycle
// - without multiplier, shift one bit per cycle
// - unit sits in six-stage execute stage
`timescale 1ns/1ps
`default_nettype none
`include "fcmdsa_cfg.svh"
module fcmdsa_alu #(
  parameter logic [1:0] MUL_OPT = `FCMDSA_MUL_DSP,
  parameter bit         DIV_EN  = 1'b1
) (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        ISSUE_IN,
  input  wire logic [3:0]  OP_IN,
  input  wire logic [31:0] A_IN,
  input  wire logic [31:0] B_IN,
  input  wire logic [4:0]  DEST_IN,
  input  wire logic [4:0]  SRC_A_IN,
  input  wire logic [4:0]  SRC_B_IN,
  output logic             READY_OUT,
  output logic             HAZARD_OUT,
  output logic             EXC_OUT,
  output logic             FAST_VALID_OUT,
  output logic [31:0]      FAST_DATA_OUT,
  output logic [4:0]       FAST_DEST_OUT,
  output logic             LONG_VALID_OUT,
  output logic [31:0]      LONG_DATA_OUT,
  output logic [4:0]       LONG_DEST_OUT
);
  localparam logic [2:0] STAGES = `FCMDSA_STAGES;
  fcmdsa_pkg::fcmdsa_st_e st_ff;
  fcmdsa_pkg::fcmdsa_st_e nxt_st;
  fcmdsa_res_if res ();

  function automatic logic is_mul(input logic [3:0] op);
    is_mul = op inside {fcmdsa_pkg::OP_MUL, fcmdsa_pkg::OP_MULI,
                        fcmdsa_pkg::OP_MULXSS, fcmdsa_pkg::OP_MULXSU,
                        fcmdsa_pkg::OP_MULXUU};
  endfunction
  function automatic logic is_hi(input logic [3:0] op);
    is_hi = op inside {fcmdsa_pkg::OP_MULXSS, fcmdsa_pkg::OP_MULXSU,
                       fcmdsa_pkg::OP_MULXUU};
  endfunction
  function automatic logic is_shf(input logic [3:0] op);
    is_shf = op inside {fcmdsa_pkg::OP_SLL, fcmdsa_pkg::OP_SRL,
                        fcmdsa_pkg::OP_SRA, fcmdsa_pkg::OP_ROL,
                        fcmdsa_pkg::OP_ROR};
  endfunction
  function automatic logic [31:0] shf1(input logic [3:0] op,
                                       input logic [31:0] v);
    case (op)
      fcmdsa_pkg::OP_SLL: shf1 = {v[30:0], 1'b0};
      fcmdsa_pkg::OP_SRL: shf1 = {1'b0, v[31:1]};
      fcmdsa_pkg::OP_SRA: shf1 = {v[31], v[31:1]};
      fcmdsa_pkg::OP_ROL: shf1 = {v[30:0], v[31]};
      default:            shf1 = {v[0], v[31:1]};
    endcase
  endfunction

  // decode
  wire logic has_mul  = (MUL_OPT != `FCMDSA_MUL_NONE);
  wire logic op_mul   = is_mul(OP_IN);
  wire logic op_div   = (OP_IN == fcmdsa_pkg::OP_DIV) ||
                        (OP_IN == fcmdsa_pkg::OP_DIVU);
  wire logic op_shf   = is_shf(OP_IN);
  // high-word forms only on the full-width multiplier
  wire logic mul_ok   = has_mul && (!is_hi(OP_IN) ||
                        MUL_OPT == `FCMDSA_MUL_DSP);
  wire logic unsup    = (op_mul && !mul_ok) || (op_div && !DIV_EN);

  // pending destination tracking
  logic        pend_ff;
  logic [4:0]  pdest_ff;
  wire logic   dep = pend_ff && ((SRC_A_IN == pdest_ff) ||
                                 (SRC_B_IN == pdest_ff));
  assign HAZARD_OUT = ISSUE_IN && dep;
  wire logic busy = (st_ff != fcmdsa_pkg::ST_IDLE);
  wire logic long_op = op_mul || op_div;
  // a second long op waits while one is pending; simple ones go
  assign READY_OUT = !busy && !dep && !(pend_ff && long_op);
  wire logic take = ISSUE_IN && READY_OUT;

  // multiplier operands
  logic [63:0] acc_ff;
  logic [31:0] mb_ff;
  logic [31:0] ma_ff;
  logic [6:0]  cnt_ff;
  logic [3:0]  op_ff;
  logic [4:0]  dest_ff;
  logic        neg_ff;
  wire logic [5:0] step = (MUL_OPT == `FCMDSA_MUL_LE) ?
                          `FCMDSA_STEP_LE : `FCMDSA_STEP_EMB;
  wire logic [6:0] mul_cpi = (MUL_OPT == `FCMDSA_MUL_LE) ? `FCMDSA_CPI_LE :
                             (MUL_OPT == `FCMDSA_MUL_EMB) ? `FCMDSA_CPI_EMB :
                             `FCMDSA_CPI_DSP;
  wire logic [31:0] chunk = (MUL_OPT == `FCMDSA_MUL_LE) ?
                            {28'h000_0000, mb_ff[3:0]} :
                            {16'h0000, mb_ff[15:0]};
  wire logic [63:0] pp = 64'(ma_ff) * 64'(chunk);

  // full 32x32 products, one per cycle
  wire logic a_s = (OP_IN == fcmdsa_pkg::OP_MULXSS) ||
                   (OP_IN == fcmdsa_pkg::OP_MULXSU);
  wire logic b_s = (OP_IN == fcmdsa_pkg::OP_MULXSS);
  wire logic signed [64:0] full_p =
    $signed({a_s & A_IN[31], A_IN}) * $signed({b_s & B_IN[31], B_IN});
  wire logic [31:0] dsp_res = is_hi(OP_IN) ? full_p[63:32] : full_p[31:0];

  // divider: restoring, magnitude based
  logic [31:0] rem_ff;
  logic [31:0] quo_ff;
  logic [31:0] dvs_ff;
  wire logic dsgn = (OP_IN == fcmdsa_pkg::OP_DIV);
  wire logic [31:0] a_mag = (dsgn && A_IN[31]) ? 32'(-A_IN) : A_IN;
  wire logic [31:0] b_mag = (dsgn && B_IN[31]) ? 32'(-B_IN) : B_IN;
  wire logic [32:0] trial = {rem_ff, quo_ff[31]} - {1'b0, dvs_ff};
  // quick path: zero dividend or zero divisor finishes in the minimum
  wire logic div_fast = (A_IN == 32'h0000_0000) || (B_IN == 32'h0000_0000);
  wire logic [6:0] div_cyc = div_fast ? `FCMDSA_DIV_MIN :
                             (`FCMDSA_DIV_MAX - `FCMDSA_LAT);

  // fast-path results
  logic [31:0] fres;
  always_comb begin
    case (OP_IN)
      fcmdsa_pkg::OP_ADD, fcmdsa_pkg::OP_ADDI: fres = 32'(A_IN + B_IN);
      fcmdsa_pkg::OP_AND: fres = A_IN & B_IN;
      fcmdsa_pkg::OP_OR:  fres = A_IN | B_IN;
      default:            fres = A_IN;
    endcase
  end
  // barrel shift when a multiplier exists
  logic [63:0] rot2;
  logic [31:0] bsh;
  wire logic [4:0] sa = B_IN[`FCMDSA_SHW-1:0];
  always_comb begin
    rot2 = {A_IN, A_IN};
    case (OP_IN)
      fcmdsa_pkg::OP_SLL: bsh = A_IN << sa;
      fcmdsa_pkg::OP_SRL: bsh = A_IN >> sa;
      fcmdsa_pkg::OP_SRA: bsh = 32'($signed(A_IN) >>> sa);
      fcmdsa_pkg::OP_ROL: bsh = rot2[6'h20 - {1'b0, sa} +: 32];
      default:            bsh = rot2[{1'b0, sa} +: 32];
    endcase
  end

  wire logic fast_go = take && !unsup && !long_op &&
                       !(op_shf && !has_mul);
  wire logic bit_go  = take && op_shf && !has_mul;
  wire logic mul_go  = take && op_mul && !unsup;
  wire logic div_go  = take && op_div && !unsup;
  wire logic mul_end = (st_ff == fcmdsa_pkg::ST_MUL) &&
                       (cnt_ff == 7'h01);
  wire logic div_end = (st_ff == fcmdsa_pkg::ST_DIV) &&
                       (cnt_ff == 7'h01);
  wire logic shf_end = (st_ff == fcmdsa_pkg::ST_SHF) &&
                       (cnt_ff == 7'h00);
  wire logic dsp_now = mul_go && (MUL_OPT == `FCMDSA_MUL_DSP);
  wire logic [31:0] qv = neg_ff ? 32'(-quo_ff) : quo_ff;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      fcmdsa_pkg::ST_IDLE: begin
        if (mul_go && !dsp_now)
          nxt_st = fcmdsa_pkg::ST_MUL;
        else if (div_go)
          nxt_st = fcmdsa_pkg::ST_DIV;
        else if (bit_go && sa != 5'h00)
          nxt_st = fcmdsa_pkg::ST_SHF;
      end
      fcmdsa_pkg::ST_MUL: if (mul_end) nxt_st = fcmdsa_pkg::ST_IDLE;
      fcmdsa_pkg::ST_DIV: if (div_end) nxt_st = fcmdsa_pkg::ST_IDLE;
      fcmdsa_pkg::ST_SHF: if (shf_end) nxt_st = fcmdsa_pkg::ST_IDLE;
      default:            nxt_st = fcmdsa_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      st_ff   <= fcmdsa_pkg::ST_IDLE;
      cnt_ff  <= 7'h00;
      acc_ff  <= 64'h0000_0000_0000_0000;
      ma_ff   <= 32'h0000_0000;
      mb_ff   <= 32'h0000_0000;
      rem_ff  <= 32'h0000_0000;
      quo_ff  <= 32'h0000_0000;
      dvs_ff  <= 32'h0000_0000;
      op_ff   <= 4'h0;
      dest_ff <= 5'h00;
      neg_ff  <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (mul_go) begin
        ma_ff   <= A_IN;
        mb_ff   <= B_IN;
        acc_ff  <= 64'h0000_0000_0000_0000;
        cnt_ff  <= mul_cpi;
        dest_ff <= DEST_IN;
      end else if (div_go) begin
        rem_ff  <= 32'h0000_0000;
        quo_ff  <= a_mag;
        dvs_ff  <= b_mag;
        neg_ff  <= dsgn && (A_IN[31] ^ B_IN[31]);
        cnt_ff  <= div_cyc;
        dest_ff <= DEST_IN;
      end else if (bit_go) begin
        ma_ff   <= A_IN;
        op_ff   <= OP_IN;
        cnt_ff  <= {2'b00, sa};
        dest_ff <= DEST_IN;
      end else if (st_ff == fcmdsa_pkg::ST_MUL) begin
        // one partial product per cycle until the word is consumed
        if (mb_ff != 32'h0000_0000) begin
          acc_ff <= acc_ff + pp;
          ma_ff  <= ma_ff << step;
          mb_ff  <= mb_ff >> step;
        end
        cnt_ff <= cnt_ff - 7'h01;
      end else if (st_ff == fcmdsa_pkg::ST_DIV) begin
        if (cnt_ff <= 7'(`FCMDSA_DIV_STEPS) + 7'h01 && !div_end &&
            dvs_ff != 32'h0000_0000) begin
          rem_ff <= trial[32] ? {rem_ff[30:0], quo_ff[31]} : trial[31:0];
          quo_ff <= {quo_ff[30:0], ~trial[32]};
        end
        cnt_ff <= cnt_ff - 7'h01;
      end else if (st_ff == fcmdsa_pkg::ST_SHF && !shf_end) begin
        ma_ff  <= shf1(op_ff, ma_ff);
        cnt_ff <= cnt_ff - 7'h01;
      end
    end
  end

  // pending scoreboard for the one outstanding long result
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      pend_ff  <= 1'b0;
      pdest_ff <= 5'h00;
    end else if ((mul_go || div_go) && DEST_IN != 5'h00) begin
      pend_ff  <= 1'b1;
      pdest_ff <= DEST_IN;
    end else if (res.valid && res.wdest == pdest_ff) begin
      pend_ff  <= 1'b0;
    end
  end

  assign res.start = dsp_now || mul_end || div_end;
  assign res.value = dsp_now ? dsp_res :
                     mul_end ? 32'(acc_ff + pp) : qv;
  assign res.dest  = dsp_now ? DEST_IN : dest_ff;
  fcmdsa_latency u_lat (
    .clk   (SYS_CLK_IN),
    .rst_n (RESET_N_IN),
    .res   (res)
  );

  // registered single-cycle results
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) begin
      FAST_VALID_OUT <= 1'b0;
      FAST_DATA_OUT  <= 32'h0000_0000;
      FAST_DEST_OUT  <= 5'h00;
      EXC_OUT        <= 1'b0;
    end else begin
      FAST_VALID_OUT <= fast_go || shf_end || (bit_go && sa == 5'h00);
      FAST_DATA_OUT  <= shf_end ? ma_ff :
                        (op_shf ? bsh : fres);
      FAST_DEST_OUT  <= shf_end ? dest_ff : DEST_IN;
      EXC_OUT        <= take && unsup;
    end
  end
  assign LONG_VALID_OUT = res.valid;
  assign LONG_DATA_OUT  = res.data;
  assign LONG_DEST_OUT  = res.wdest;
  logic [6:0] mul_gap_ff; // cycles since last multiply, saturating
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESET_N_IN) mul_gap_ff <= 7'h7F;
    else mul_gap_ff <= mul_go ? 7'h01 : mul_gap_ff + {6'h00, ~&mul_gap_ff};
  end
  property p_exc;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      (take && unsup) |=> EXC_OUT && !LONG_VALID_OUT;
  endproperty
  a_exc: assert property (p_exc) else $error("unsupported op not trapped");
  property p_le_cpi;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      (mul_go && MUL_OPT == `FCMDSA_MUL_LE) |-> mul_gap_ff >= `FCMDSA_CPI_LE;
  endproperty
  a_le_cpi: assert property (p_le_cpi) else $error("le multiply too fast");
  sequence s_dsp_go;
    dsp_now;
  endsequence
  property p_dsp_lat;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      s_dsp_go |=> ##1 LONG_VALID_OUT && LONG_DEST_OUT == $past(DEST_IN, 2);
  endproperty
  a_dsp_lat: assert property (p_dsp_lat) else $error("dsp latency wrong");
  property p_emb_cpi;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      (mul_go && MUL_OPT == `FCMDSA_MUL_EMB) |=> !READY_OUT [*4];
  endproperty
  a_emb_cpi: assert property (p_emb_cpi) else $error("emb multiply too fast");
  property p_div_bnd;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      div_go |-> ##[5:67] LONG_VALID_OUT;
  endproperty
  a_div_bnd: assert property (p_div_bnd) else $error("divide out of range");
  property p_busy;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      busy |-> !READY_OUT;
  endproperty
  a_busy: assert property (p_busy) else $error("issue while busy");
  property p_fast;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      fast_go |=> FAST_VALID_OUT && FAST_DEST_OUT == $past(DEST_IN);
  endproperty
  a_fast: assert property (p_fast) else $error("simple op not one cycle");
  property p_bshift;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      (take && op_shf && has_mul) |=> FAST_VALID_OUT;
  endproperty
  a_bshift: assert property (p_bshift) else $error("shift not one cycle");
  property p_release;
    @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      (pend_ff && LONG_VALID_OUT && LONG_DEST_OUT == pdest_ff) |=> !pend_ff;
  endproperty
  a_release: assert property (p_release) else $error("stall not released");
endmodule
`default_nettype wire

// >>> tb/fcmdsa_issue_model.sv
`timescale 1ns/1ps
`default_nettype none
// issue side of the pipeline: offers up to two ops back to back
module fcmdsa_issue_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        start_in,
  input  wire logic        two_in,
  input  wire logic [82:0] op0_in,
  input  wire logic [82:0] op1_in,
  input  wire logic        ready_in,
  output logic             issue_out,
  output logic [82:0]      word_out,
  output logic [1:0]       left_out
);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      issue_out <= 1'b0;
      word_out  <= '0;
      left_out  <= 2'h0;
    end else if (start_in && !issue_out) begin
      issue_out <= 1'b1;
      word_out  <= op0_in;
      left_out  <= two_in ? 2'h2 : 2'h1;
    end else if (issue_out && ready_in && left_out == 2'h2) begin
      // next op follows at once, no wait on latency
      word_out <= op1_in;
      left_out <= 2'h1;
    end else if (issue_out && ready_in) begin
      issue_out <= 1'b0;
      // released lines must not keep showing the last op
      word_out  <= ~word_out;
      left_out  <= 2'h0;
    end
    // otherwise hold the offer while stalled
  end
endmodule
`default_nettype wire

// >>> tb/tb_fast_core_mul_div_shift_alu.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcmdsa_cfg.svh"
module tb_fast_core_mul_div_shift_alu;
  typedef struct {
    fcmdsa_pkg::fcmdsa_op_e op;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] exp;
    bit          lng;
    logic [31:0] lat;
  } fcmdsa_row_s;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        start = 1'b0;
  logic        two_r = 1'b0;
  logic [82:0] op0 = '0;
  logic [82:0] op1 = '0;
  logic [82:0] word;
  logic [1:0]  left;
  logic        issue;
  logic        ready, hazard, exc, fvalid, lvalid;
  logic [31:0] fdata, ldata, d_fast, d_long;
  logic [4:0]  fdest, ldest, d_dst;
  logic        exc2, fv2;
  logic [31:0] fd2, d_fast2;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n_fast = 0, n_long = 0, n_hz = 0, hz0;
  int          n_ex0 = 0, n_ex2 = 0, ex_base, t_fast2;
  int          t_tk, t_first, t_fast, t_long;
  fcmdsa_row_s rows [17];
  fcmdsa_row_s r;

  always #25 clk = ~clk;

  fcmdsa_issue_model u_issue (
    .clk_in(clk), .rst_n_in(rst_n), .start_in(start), .two_in(two_r),
    .op0_in(op0), .op1_in(op1), .ready_in(ready), .issue_out(issue),
    .word_out(word), .left_out(left)
  );

  fcmdsa_alu #(.MUL_OPT(`FCMDSA_MUL_DSP), .DIV_EN(1'b1)) dut (
    .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .ISSUE_IN(issue),
    .OP_IN(word[82:79]), .A_IN(word[78:47]), .B_IN(word[46:15]),
    .DEST_IN(word[14:10]), .SRC_A_IN(word[9:5]), .SRC_B_IN(word[4:0]),
    .READY_OUT(ready), .HAZARD_OUT(hazard), .EXC_OUT(exc),
    .FAST_VALID_OUT(fvalid), .FAST_DATA_OUT(fdata),
    .FAST_DEST_OUT(fdest), .LONG_VALID_OUT(lvalid),
    .LONG_DATA_OUT(ldata), .LONG_DEST_OUT(ldest)
  );

  // bare option: no multiplier, no divider, bit-serial shifts
  fcmdsa_alu #(.MUL_OPT(`FCMDSA_MUL_NONE), .DIV_EN(1'b0)) dut_bare (
    .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .ISSUE_IN(issue),
    .OP_IN(word[82:79]), .A_IN(word[78:47]), .B_IN(word[46:15]),
    .DEST_IN(word[14:10]), .SRC_A_IN(word[9:5]), .SRC_B_IN(word[4:0]),
    .READY_OUT(), .HAZARD_OUT(), .EXC_OUT(exc2),
    .FAST_VALID_OUT(fv2), .FAST_DATA_OUT(fd2), .FAST_DEST_OUT(),
    .LONG_VALID_OUT(), .LONG_DATA_OUT(), .LONG_DEST_OUT()
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [82:0] pack(input logic [3:0] op,
    input logic [31:0] a, input logic [31:0] b, input logic [4:0] d,
    input logic [4:0] sa, input logic [4:0] sb);
    return {op, a, b, d, sa, sb};
  endfunction

  // sampled mid-cycle so comb ready and registered pulses are settled
  always @(negedge clk) begin
    if (issue && ready) begin
      if (left == 2'h2)
        t_first = cyc;
      t_tk = cyc;
    end
    if (hazard)
      n_hz++;
    if (fvalid) begin
      n_fast++;
      t_fast = cyc;
      d_fast = fdata;
    end
    if (lvalid) begin
      n_long++;
      t_long = cyc;
      d_long = ldata;
      d_dst  = ldest;
    end
    if (exc)
      n_ex0++;
    if (exc2)
      n_ex2++;
    if (fv2) begin
      t_fast2 = cyc;
      d_fast2 = fd2;
    end
  end

  // divides dominate: 3 of 66 cycles plus margin for every case
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic go(input logic [82:0] w0, input logic [82:0] w1,
    input bit two, input int nf, input int nl);
    int bf;
    int bl;
    int k;
    bf = n_fast;
    bl = n_long;
    @(posedge clk);
    start <= 1'b1;
    op0   <= w0;
    op1   <= w1;
    two_r <= two;
    @(posedge clk);
    start <= 1'b0;
    for (k = 0; k < 200; k++) begin
      @(posedge clk);
      if (n_fast >= bf + nf && n_long >= bl + nl)
        break;
    end
    check(32'(k < 200), 32'h0000_0001);
    $display("case done at %0t", $time);
  endtask

  initial begin
    rows = '{
      '{fcmdsa_pkg::OP_ADD, 32'h0000_0005, 32'h0000_0003, 32'h0000_0008, 0, 1},
      '{fcmdsa_pkg::OP_ADDI, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0, 0, 1},
      '{fcmdsa_pkg::OP_AND, 32'hF0F0_F0F0, 32'hFF00_FF00, 32'hF000_F000, 0, 1},
      '{fcmdsa_pkg::OP_OR, 32'h0F00_0000, 32'h0000_00F0, 32'h0F00_00F0, 0, 1},
      '{fcmdsa_pkg::OP_SLL, 32'h0000_0001, 32'h0000_0004, 32'h0000_0010, 0, 1},
      '{fcmdsa_pkg::OP_SRL, 32'h8000_0000, 32'h0000_001F, 32'h0000_0001, 0, 1},
      '{fcmdsa_pkg::OP_SRA, 32'h8000_0000, 32'h0000_0004, 32'hF800_0000, 0, 1},
      '{fcmdsa_pkg::OP_ROL, 32'h8000_0001, 32'h0000_0001, 32'h0000_0003, 0, 1},
      '{fcmdsa_pkg::OP_ROR, 32'h0000_0001, 32'h0000_0001, 32'h8000_0000, 0, 1},
      '{fcmdsa_pkg::OP_MUL, 32'h0000_0007, 32'h0000_0006, 32'h0000_002A, 1, 2},
      '{fcmdsa_pkg::OP_MULI, 32'h0000_0003, 32'h0000_0004, 32'h0000_000C, 1, 2},
      '{fcmdsa_pkg::OP_MULXSS, 32'hFFFF_FFFF, 32'h2, 32'hFFFF_FFFF, 1, 2},
      '{fcmdsa_pkg::OP_MULXSU, 32'hFFFF_FFFF, 32'h2, 32'hFFFF_FFFF, 1, 2},
      '{fcmdsa_pkg::OP_MULXUU, 32'hFFFF_FFFF, 32'h2, 32'h0000_0001, 1, 2},
      '{fcmdsa_pkg::OP_DIV, 32'hFFFF_FFF8, 32'h2, 32'hFFFF_FFFC, 1, 66},
      '{fcmdsa_pkg::OP_DIVU, 32'hFFFF_FFF8, 32'h2, 32'h7FFF_FFFC, 1, 66},
      '{fcmdsa_pkg::OP_DIV, 32'h0000_0000, 32'h0000_0005, 32'h0, 1, 6}
    };
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(32'({fvalid, lvalid, exc}), 32'h0000_0000);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(32'(ready), 32'h0000_0001);
    foreach (rows[i]) begin
      r = rows[i];
      go(pack(r.op, r.a, r.b, 5'h01, 5'h00, 5'h00), '0, 1'b0,
         r.lng ? 0 : 1, r.lng ? 1 : 0);
      if (r.lng) begin
        check(d_long, r.exp);
        check(32'(t_long - t_tk), r.lat);
      end else begin
        check(d_fast, r.exp);
        check(32'(t_fast - t_tk), r.lat);
      end
    end
    // dependent add right behind a multiply
    hz0 = n_hz;
    go(pack(fcmdsa_pkg::OP_MUL, 32'h7, 32'h6, 5'h03, 5'h00, 5'h00),
       pack(fcmdsa_pkg::OP_ADDI, 32'h2A, 32'h64, 5'h00, 5'h03, 5'h00),
       1'b1, 1, 1);
    check(32'(n_hz > hz0), 32'h0000_0001);
    check(32'(t_tk - t_long), 32'h0000_0001);
    check(32'(t_tk - t_first), 32'(1 + `FCMDSA_LAT));
    check(d_fast, 32'h0000_008E);
    check(32'(d_dst), 32'h0000_0003);
    // independent op slips in behind the multiply
    go(pack(fcmdsa_pkg::OP_MUL, 32'h2, 32'h3, 5'h03, 5'h00, 5'h00),
       pack(fcmdsa_pkg::OP_OR, 32'h0F, 32'hF0, 5'h00, 5'h05, 5'h06),
       1'b1, 1, 1);
    check(32'(t_tk - t_first), 32'h0000_0001);
    check(d_fast, 32'h0000_00FF);
    check(32'(t_long - t_first), 32'h0000_0002);
    check(d_long, 32'h0000_0006);
    // bare option: bit-serial shift, trapped multiply and divide
    go(pack(fcmdsa_pkg::OP_SLL, 32'h3, 32'h4, 5'h02, 5'h00, 5'h00), '0,
       1'b0, 1, 0);
    repeat (8) @(posedge clk);
    check(d_fast2, 32'h0000_0030);
    check(32'(t_fast2 - t_tk > 4), 32'h0000_0001);
    ex_base = n_ex2;
    go(pack(fcmdsa_pkg::OP_MUL, 32'h2, 32'h3, 5'h02, 5'h00, 5'h00), '0,
       1'b0, 0, 1);
    go(pack(fcmdsa_pkg::OP_DIVU, 32'h8, 32'h2, 5'h04, 5'h00, 5'h00), '0,
       1'b0, 0, 1);
    check(32'(n_ex2 - ex_base), 32'h0000_0002);
    check(32'(n_ex0), 32'h0000_0000);
    check(d_long, 32'h0000_0004);
    conclude();
  end
endmodule
`default_nettype wire
